// ### common/ebc_pkg.sv
// Constants, field layouts and carrier types for the external bus control.
// Assumes one 100 MHz clock, synchronous active-high reset.
// How it works
// - Follow-window stretch code adds 0-3 bus clocks
// - Follow-window stretch ignores the narrow option
// - External stretch code adds 0-3 bus clocks
// - No stretch in single-chip or peripheral mode
// - Flash enable bits map or unmap arrays
// - Strobe and A0 both high on odd-address word access
// - Byte access: strobe and A0 mark lane
// - Word access: both low aligned, high swapped
// - Bus is 8 or 16 bits wide
// - Narrow option mixes 8/16-bit peripherals in wide expanded mode
// - Peripheral mode drops first sixteen bus registers
// - Expanded modes move port A/B registers out
// - Emulate bit moves port E registers out
// - Port A carries high address and data
// - Unused port A follows its direction bits
// - Port A direction mapped only in single-chip
// - Narrow window accesses use port A only
// - Follow window sits after register block
`default_nettype none
package ebc_pkg;
    localparam logic [7:0]  OFS_PORT_A_DATA = 8'h00;
    localparam logic [7:0]  OFS_PORT_B_DATA = 8'h01;
    localparam logic [7:0]  OFS_PORT_A_DIR  = 8'h02;
    localparam logic [7:0]  OFS_PORT_B_DIR  = 8'h03;
    localparam logic [7:0]  OFS_PORT_E_DATA = 8'h08;
    localparam logic [7:0]  OFS_PORT_E_DIR  = 8'h09;
    localparam logic [7:0]  OFS_MODE        = 8'h0B;
    localparam logic [7:0]  OFS_MISC        = 8'h13;
    localparam logic [7:0]  OFS_STATUS      = 8'h1F;
    localparam logic [15:0] BUS_REG_SPAN    = 16'h0010;
    localparam logic [15:0] REG_BLOCK_SPAN  = 16'h0200;
    localparam logic [15:0] FOLLOW_SPAN     = 16'h0200;
    localparam logic [15:0] SMALL_FLASH_LO  = 16'h1000;
    localparam logic [15:0] LARGE_FLASH_LO  = 16'h8000;
    localparam int          MISC_FOLLOW_NARROW = 6;
    localparam int          MISC_FOLLOW_STR_LO = 4;
    localparam int          MISC_EXT_STR_LO    = 2;
    localparam int          MISC_SMALL_FLASH   = 1;
    localparam int          MISC_LARGE_FLASH   = 0;
    localparam int          MODE_EMULATE_E     = 0;
    localparam logic [7:0]  MISC_RESET_EXP  = 8'h0C;
    localparam logic [7:0]  MISC_RESET_SC   = 8'h0F;
    localparam logic [7:0]  DIR_RESET       = 8'h00;
    localparam int          BUS_DIV         = 4;
    localparam logic [1:0]  BUS_DIV_LAST    = 2'(BUS_DIV - 1);

    typedef enum logic [1:0] {
        EBC_SINGLE   = 2'h0,
        EBC_EXP_WIDE = 2'h1,
        EBC_EXP_NARR = 2'h2,
        EBC_PERIPH   = 2'h3
    } ebc_mode_t;

    typedef enum logic [1:0] {
        EBC_IDLE    = 2'h0,
        EBC_ADDR    = 2'h1,
        EBC_STRETCH = 2'h2,
        EBC_DATA    = 2'h3
    } ebc_phase_t;

    // One internal access request from the core
    typedef struct packed {
        logic        req;
        logic [15:0] addr;
        logic        wide;
        logic        read;
        logic [15:0] wdata;
    } ebc_acc_t;

    // Bus control pins as seen outside
    typedef struct packed {
        logic low_byte_strobe_n;
        logic addr0;
        logic read_not_write;
        logic bus_clock_out;
    } ebc_ctl_t;
endpackage
`default_nettype wire

// ### hw/ebc_decode.sv
// Address decoder: classifies an access into a target and stretch.
// Assumes the mapping bases come from registered control, same clock.
`default_nettype none
module ebc_decode
    import ebc_pkg::*;
(
    input  wire logic [15:0] addr,
    input  wire logic [4:0]  reg_base,
    input  wire ebc_mode_t   mode,
    input  wire logic [7:0]  misc,
    input  wire logic        emulate_e,
    output logic             hit_reg,
    output logic             hit_ram,
    output logic             hit_flash,
    output logic             hit_follow,
    output logic [1:0]       stretch,
    output logic             narrow
);
    logic [15:0] base;
    logic [15:0] off;
    logic        exp;
    logic        ext_reg;
    always_comb begin
        base = {reg_base, 11'h000};
        off = addr - base;
        exp = (mode == EBC_EXP_WIDE) || (mode == EBC_EXP_NARR);
        ext_reg = 1'b0;
        if (exp && (off < 16'h0004)) begin
            ext_reg = 1'b1;
        end
        if (exp && emulate_e
            && (off[15:1] == 15'(OFS_PORT_E_DATA[7:1]))) begin
            ext_reg = 1'b1;
        end
        if ((mode == EBC_PERIPH) && (off < BUS_REG_SPAN)) begin
            ext_reg = 1'b1;
        end
        hit_reg = (off < REG_BLOCK_SPAN) && !ext_reg;
        // Window tracks the register block base
        hit_follow = (off >= REG_BLOCK_SPAN)
            && (off < REG_BLOCK_SPAN + FOLLOW_SPAN);
        hit_ram = (addr[15:11] == 5'h01) && !hit_reg && !hit_follow;
        // Unmapped arrays fall through to external space
        hit_flash = (misc[MISC_SMALL_FLASH] && addr >= SMALL_FLASH_LO
                     && addr < LARGE_FLASH_LO)
                 || (misc[MISC_LARGE_FLASH] && addr >= LARGE_FLASH_LO);
        hit_flash = hit_flash && !hit_reg && !hit_ram && !hit_follow;
        // Narrow option only meaningful in wide expanded mode
        narrow = (mode == EBC_EXP_NARR)
            || (mode == EBC_EXP_WIDE && hit_follow
                && misc[MISC_FOLLOW_NARROW]);
        stretch = 2'h0;
        if (exp && hit_follow) begin
            // Independent of the narrow bit
            stretch = misc[MISC_FOLLOW_STR_LO +: 2];
        end else if (exp && !hit_reg && !hit_ram && !hit_flash) begin
            stretch = misc[MISC_EXT_STR_LO +: 2];
        end
        if (!exp) begin
            stretch = 2'h0;
        end
    end
endmodule
`default_nettype wire

// ### hw/ebc_top.sv
// External bus controller: register port, stretch sequencer, port A.
// Assumes mode straps are stable after reset; port A pins are async.
`default_nettype none
module ebc_top
    import ebc_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire ebc_pkg::ebc_mode_t mode_strap,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [7:0]       reg_rdata,
    input  wire ebc_pkg::ebc_acc_t acc,
    output logic             acc_done,
    output logic [15:0]      acc_rdata,
    output logic             acc_internal,
    output ebc_pkg::ebc_ctl_t bus_ctl,
    output logic [15:0]      bus_ad_out,
    output logic [15:0]      bus_ad_oe,
    input  wire logic [7:0]  port_b_in,
    input  wire logic [7:0]  port_a_in,
    output logic [7:0]       port_a_out,
    output logic [7:0]       port_a_oe
);
    typedef struct packed {
        ebc_mode_t   mode;
        logic        strap_done;
        logic [7:0]  misc;
        logic        emulate_e;
        logic [7:0]  pa_data;
        logic [7:0]  pa_dir;
        logic [7:0]  rdata;
        logic [7:0]  pa_s1;
        logic [7:0]  pa_s2;
        logic [7:0]  pb_s1;
        logic [7:0]  pb_s2;
        logic [1:0]  div;
        ebc_phase_t  phase;
        logic [1:0]  left;
        ebc_acc_t    cur;
        logic        swap;
        logic        narrow;
        logic        low_done;
        logic [7:0]  low_byte;
        logic        done;
        logic        internal;
        logic [15:0] ardata;
        ebc_ctl_t    ctl;
        logic [15:0] ad_out;
        logic [15:0] ad_oe;
        logic [7:0]  pa_out;
        logic [7:0]  pa_oe;
    } ebc_state_t;

    ebc_state_t s_q;
    ebc_state_t s_d;
    logic       hit_reg;
    logic       hit_ram;
    logic       hit_flash;
    logic       hit_follow;
    logic [1:0] stretch;
    logic       narrow;
    logic       exp;
    logic       pa_mapped;
    logic       tick;
    logic [15:0] bus_in;

    ebc_decode u_dec (
        .addr       (acc.addr),
        .reg_base   (5'h00),
        .mode       (s_q.mode),
        .misc       (s_q.misc),
        .emulate_e  (s_q.emulate_e),
        .hit_reg    (hit_reg),
        .hit_ram    (hit_ram),
        .hit_flash  (hit_flash),
        .hit_follow (hit_follow),
        .stretch    (stretch),
        .narrow     (narrow)
    );

    always_comb begin
        s_d = s_q;
        exp = (s_q.mode == EBC_EXP_WIDE) || (s_q.mode == EBC_EXP_NARR);
        pa_mapped = (s_q.mode == EBC_SINGLE);
        tick = (s_q.div == BUS_DIV_LAST);
        bus_in = {s_q.pa_s2, s_q.pb_s2};
        s_d.done = 1'b0;
        s_d.div = s_q.div + 2'h1;
        // Two-stage sync; only stage two feeds logic
        s_d.pa_s1 = port_a_in;
        s_d.pa_s2 = s_q.pa_s1;
        s_d.pb_s1 = port_b_in;
        s_d.pb_s2 = s_q.pb_s1;
        // Straps caught once, after release of reset
        if (!s_q.strap_done) begin
            s_d.strap_done = 1'b1;
            s_d.mode = mode_strap;
            s_d.misc = (mode_strap == EBC_SINGLE) ? MISC_RESET_SC
                                                  : MISC_RESET_EXP;
        end
        // Register port; mapped registers vanish when bus owns pins
        s_d.rdata = 8'h00;
        if (reg_wr) begin
            unique case (reg_addr)
                OFS_PORT_A_DATA: if (pa_mapped) s_d.pa_data = reg_wdata;
                OFS_PORT_A_DIR:  if (pa_mapped) s_d.pa_dir = reg_wdata;
                OFS_MISC:        s_d.misc = reg_wdata;
                OFS_MODE:        s_d.emulate_e = reg_wdata[MODE_EMULATE_E];
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                OFS_PORT_A_DATA: if (pa_mapped)
                    s_d.rdata = (s_q.pa_dir & s_q.pa_data)
                              | (~s_q.pa_dir & s_q.pa_s2);
                OFS_PORT_A_DIR:  if (pa_mapped) s_d.rdata = s_q.pa_dir;
                OFS_MISC:        s_d.rdata = s_q.misc;
                OFS_MODE:        s_d.rdata = {7'h00, s_q.emulate_e};
                OFS_STATUS:      s_d.rdata = {4'h0, s_q.phase,
                                              s_q.mode};
                default: ;
            endcase
        end
        // Port A as general I/O outside bus use
        if (!exp && s_q.mode != EBC_PERIPH) begin
            s_d.pa_out = s_q.pa_data;
            s_d.pa_oe = s_q.pa_dir;
        end else begin
            s_d.pa_out = s_q.ad_out[15:8];
            s_d.pa_oe = s_q.ad_oe[15:8];
        end
        // Bus clock phase output
        if (tick) begin
            s_d.ctl.bus_clock_out = ~s_q.ctl.bus_clock_out;
        end
        unique case (s_q.phase)
            EBC_IDLE: begin
                s_d.ctl.bus_clock_out = 1'b0;
                // Done cycle refused: a held request is not taken twice
                if (acc.req && s_q.strap_done && !s_q.done) begin
                    if (hit_reg || hit_ram || hit_flash || !exp) begin
                        // Internal: answered at once, no bus cycle
                        s_d.done = 1'b1;
                        s_d.internal = 1'b1;
                        s_d.ardata = 16'h0000;
                    end else begin
                        s_d.internal = 1'b0;
                        s_d.cur = acc;
                        s_d.left = stretch;
                        s_d.narrow = narrow;
                        s_d.swap = acc.wide && acc.addr[0];
                        s_d.low_done = 1'b0;
                        s_d.div = 2'h0;
                        s_d.phase = EBC_ADDR;
                        s_d.ctl.read_not_write = acc.read;
                        s_d.ctl.addr0 = acc.addr[0];
                        // Byte vs word lane marking
                        s_d.ctl.low_byte_strobe_n = acc.wide
                            ? acc.addr[0] : !acc.addr[0];
                        // Odd-word external can take the narrow path; swap then has no effect on port A
                        s_d.ad_out = acc.addr;
                        s_d.ad_oe = 16'hFFFF;
                    end
                end
            end
            EBC_ADDR: begin
                if (tick) begin
                    s_d.phase = (s_q.left != 2'h0) ? EBC_STRETCH
                                                   : EBC_DATA;
                    if (s_q.cur.read) begin
                        s_d.ad_oe = 16'h0000;
                    end else begin
                        s_d.ad_oe = 16'hFFFF;
                        s_d.ad_out = s_q.swap
                            ? {s_q.cur.wdata[7:0], s_q.cur.wdata[15:8]}
                            : s_q.cur.wdata;
                        if (s_q.narrow) begin
                            s_d.ad_out[15:8] = s_q.low_done
                                ? s_q.cur.wdata[7:0]
                                : s_q.cur.wdata[15:8];
                        end
                    end
                end
            end
            EBC_STRETCH: begin
                // Phase held while bus clocks are added
                if (tick && s_q.ctl.bus_clock_out) begin
                    s_d.left = s_q.left - 2'h1;
                    if (s_q.left == 2'h1) begin
                        s_d.phase = EBC_DATA;
                    end
                end
            end
            EBC_DATA: begin
                if (tick && s_q.ctl.bus_clock_out) begin
                    if (s_q.narrow && s_q.cur.wide && !s_q.low_done) begin
                        // Second byte through port A only
                        s_d.low_byte = bus_in[15:8];
                        s_d.low_done = 1'b1;
                        s_d.cur.addr = s_q.cur.addr + 16'h0001;
                        s_d.ad_out = s_q.cur.addr + 16'h0001;
                        s_d.ad_oe = 16'hFFFF;
                        s_d.ctl.addr0 = ~s_q.ctl.addr0;
                        // Second byte keeps the first byte's class
                        s_d.left = stretch;
                        s_d.phase = EBC_ADDR;
                    end else begin
                        s_d.done = 1'b1;
                        if (s_q.narrow && s_q.cur.wide) begin
                            s_d.ardata = {s_q.low_byte, bus_in[15:8]};
                        end else if (s_q.narrow) begin
                            s_d.ardata = {8'h00, bus_in[15:8]};
                        end else if (s_q.swap) begin
                            s_d.ardata = {bus_in[7:0], bus_in[15:8]};
                        end else begin
                            s_d.ardata = bus_in;
                        end
                        s_d.ad_oe = 16'h0000;
                        s_d.phase = EBC_IDLE;
                    end
                end
            end
        endcase
        // Next-state narrow, so the first address cycle is masked too
        if (s_d.narrow) begin
            s_d.ad_oe[7:0] = 8'h00;
        end
        // Strobe/A0 both high for odd-address word accesses are set in IDLE when the request is taken
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.misc <= MISC_RESET_EXP;
            s_q.pa_dir <= DIR_RESET;
            s_q.ctl <= '{1'b1, 1'b0, 1'b1, 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    assign acc_done = s_q.done;
    assign acc_rdata = s_q.ardata;
    assign acc_internal = s_q.internal;
    assign bus_ctl = s_q.ctl;
    assign bus_ad_out = s_q.ad_out;
    assign bus_ad_oe = s_q.ad_oe;
    assign port_a_out = s_q.pa_out;
    assign port_a_oe = s_q.pa_oe;
endmodule
`default_nettype wire

// ### dv/ebc_checker.sv
// Port checker for the external bus control block.
// Assumes it is bound to ebc_top; one clock, synchronous reset.
`default_nettype none
module ebc_checker
    import ebc_pkg::*;
(
    input wire logic               clk,
    input wire logic               rst,
    input wire ebc_pkg::ebc_mode_t mode_strap,
    input wire logic               reg_rd,
    input wire logic [7:0]         reg_rdata,
    input wire ebc_pkg::ebc_acc_t  acc,
    input wire logic               acc_done,
    input wire logic               acc_internal,
    input wire ebc_pkg::ebc_ctl_t  bus_ctl,
    input wire logic [15:0]        bus_ad_oe
);
    logic act;
    assign act = acc.req && |bus_ad_oe;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_rd_idle;
        !$past(reg_rd) |-> reg_rdata == 8'h00;
    endproperty
    property p_byte_lane;
        act && !acc.wide |-> bus_ctl.low_byte_strobe_n == !acc.addr[0]
            && bus_ctl.addr0 == acc.addr[0];
    endproperty
    property p_rnw;
        act |-> bus_ctl.read_not_write == acc.read;
    endproperty
    // Follow window excluded: it may run as an 8-bit bus
    property p_word;
        act && acc.wide && mode_strap == EBC_EXP_WIDE
            && acc.addr[15:9] != 7'h01
            |-> bus_ctl.low_byte_strobe_n == acc.addr[0]
            && bus_ctl.addr0 == acc.addr[0];
    endproperty
    property p_done_bound;
        $rose(acc.req) |-> ##[1:120] acc_done;
    endproperty
    property p_hold;
        act && $past(act) |-> $stable(bus_ctl.read_not_write);
    endproperty
    property p_done_pulse;
        acc_done |=> !acc_done;
    endproperty
    property p_port_ext;
        acc_done && mode_strap inside {EBC_EXP_WIDE, EBC_EXP_NARR}
            && acc.addr[15:2] == 14'h0000 |-> !acc_internal;
    endproperty
    property p_port_int;
        acc_done && mode_strap == EBC_SINGLE && acc.addr == 16'h0000
            |-> acc_internal;
    endproperty

    a_rd_idle: assert property (p_rd_idle)
        else $error("read data not idle");
    a_byte_lane: assert property (p_byte_lane)
        else $error("byte lane code wrong");
    a_rnw: assert property (p_rnw)
        else $error("read write line wrong");
    a_word: assert property (p_word)
        else $error("word lane code wrong");
    a_done_bound: assert property (p_done_bound)
        else $error("access never completed");
    a_hold: assert property (p_hold)
        else $error("control moved mid access");
    a_done_pulse: assert property (p_done_pulse)
        else $error("done longer than a cycle");
    a_port_ext: assert property (p_port_ext)
        else $error("port register stayed on chip");
    a_port_int: assert property (p_port_int)
        else $error("port register left the map");

    c_odd_word: cover property (act && acc.wide && acc.addr[0]);
    c_ext_done: cover property (acc_done && !acc_internal);
    c_reg_read: cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

bind ebc_top ebc_checker ebc_checker_i (
    .clk, .rst, .mode_strap, .reg_rd, .reg_rdata, .acc, .acc_done,
    .acc_internal, .bus_ctl, .bus_ad_oe
);
`default_nettype wire

// ### dv/ebc_mem_model.sv
// Far-side memory: answers reads with a pattern made from the address.
// Assumes the address phase drives at least port A with oe high.
`default_nettype none
module ebc_mem_model
    import ebc_pkg::*;
(
    input  wire logic              clk,
    input  wire ebc_pkg::ebc_ctl_t bus_ctl,
    input  wire logic [15:0]       bus_ad_out,
    input  wire logic [15:0]       bus_ad_oe,
    output logic [7:0]             port_a_in,
    output logic [7:0]             port_b_in
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] addr_q = 16'h0000;
    logic        rnw_q = 1'b1;
    logic        oe_q = 1'b0;
    logic [15:0] mem;

    always_ff @(posedge clk) begin
        // Narrow cycles drive the address on port A only
        oe_q <= &bus_ad_oe[15:8];
        if (&bus_ad_oe[15:8] && !oe_q) begin
            addr_q <= bus_ad_out;
            rnw_q  <= bus_ctl.read_not_write;
        end
    end
    // Held for as long as the device stretches; no bus value on writes
    assign mem = rnw_q ? {addr_q[7:0] ^ 8'h5A, ~addr_q[7:0]}
                       : ~addr_q;
    // Wire level: the device where it drives, else the model
    assign port_a_in = (bus_ad_out[15:8] & bus_ad_oe[15:8])
                     | (mem[15:8] & ~bus_ad_oe[15:8]);
    assign port_b_in = (bus_ad_out[7:0] & bus_ad_oe[7:0])
                     | (mem[7:0] & ~bus_ad_oe[7:0]);
endmodule
`default_nettype wire

// ### dv/external_bus_access_control_bench.sv
// Self-checking bench for the external bus control block.
// Assumes ebc_top, its checker and the memory model are compiled first.
`default_nettype none
module external_bus_access_control_bench import ebc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    ebc_mode_t   mode_strap = EBC_SINGLE;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    ebc_acc_t    acc = '0;
    logic        acc_done;
    logic        acc_internal;
    logic [15:0] acc_rdata;
    ebc_ctl_t    bus_ctl;
    logic [15:0] bus_ad_out;
    logic [15:0] bus_ad_oe;
    logic [7:0]  port_a_in;
    logic [7:0]  port_b_in;
    logic [7:0]  port_a_out;
    logic [7:0]  port_a_oe;
    int          n_errors = 0;
    int          tests_run = 0;
    int          lat;
    int          base;
    int          fbase;
    logic [7:0]  rdv;

    always #5 clk = ~clk;

    ebc_top ebc_top_i (
        .clk, .rst, .mode_strap, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .acc, .acc_done, .acc_rdata, .acc_internal, .bus_ctl,
        .bus_ad_out, .bus_ad_oe, .port_b_in, .port_a_in, .port_a_out,
        .port_a_oe
    );
    ebc_mem_model ebc_mem_model_i (
        .clk, .bus_ctl, .bus_ad_out, .bus_ad_oe, .port_a_in, .port_b_in
    );

    task automatic chk(input logic [15:0] seen, exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, exp, input string what);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rdv = reg_rdata;
        chk(16'(rdv), 16'(exp), what);
    endtask
    // Request held up to the edge that samples done high
    task automatic go(input logic [15:0] a, input logic w, r);
        @(posedge clk);
        acc <= '{1'b1, a, w, r, 16'hC3A5};
        lat = 0;
        do begin
            @(posedge clk);
            #1 lat++;
        end while (acc_done !== 1'b1 && lat < 200);
        chk(16'(acc_done), 16'h0001, "acc done");
        @(posedge clk);
        acc.req <= 1'b0;
    endtask
    task automatic boot(input ebc_mode_t m);
        @(posedge clk);
        rst <= 1'b1;
        mode_strap <= m;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    initial begin
        boot(EBC_SINGLE);
        rchk(OFS_MISC, MISC_RESET_SC, "misc sc");
        rchk(OFS_PORT_A_DIR, DIR_RESET, "dir reset");
        wr(OFS_PORT_A_DIR, 8'hF0);
        wr(OFS_PORT_A_DATA, 8'hA5);
        rchk(OFS_PORT_A_DIR, 8'hF0, "dir rw");
        // Input bits show the model's idle pattern 8'h5A
        rchk(OFS_PORT_A_DATA, 8'hAA, "pa read");
        rchk(8'h04, 8'h00, "unmapped");
        repeat (3) @(posedge clk);
        #1 chk(16'(port_a_oe), 16'h00F0, "pa oe");
        chk(16'(port_a_out & port_a_oe), 16'h00A0, "pa out");
        go(16'h0000, 1'b0, 1'b1);
        chk(16'(acc_internal), 16'h0001, "pa internal");
        go(16'h0300, 1'b0, 1'b1);
        base = lat;
        wr(OFS_MISC, 8'h3F);
        go(16'h0300, 1'b0, 1'b1);
        chk(16'(lat), 16'(base), "sc stretch");

        boot(EBC_EXP_WIDE);
        rchk(OFS_MISC, MISC_RESET_EXP, "misc exp");
        wr(OFS_PORT_A_DIR, 8'hFF);
        rchk(OFS_PORT_A_DIR, 8'h00, "dir exp");
        go(16'h0000, 1'b0, 1'b1);
        chk(16'(acc_internal), 16'h0000, "pa external");
        go(16'h0008, 1'b0, 1'b1);
        chk(16'(acc_internal), 16'h0001, "pe internal");
        wr(OFS_MODE, 8'h01);
        go(16'h0008, 1'b0, 1'b1);
        chk(16'(acc_internal), 16'h0000, "pe external");
        go(16'h4012, 1'b1, 1'b1);
        chk(acc_rdata, 16'h48ED, "word read");
        chk(16'(acc_internal), 16'h0000, "flash off");
        go(16'h4013, 1'b1, 1'b0);
        go(16'h4001, 1'b0, 1'b0);
        wr(OFS_MISC, 8'h0D);
        go(16'h9000, 1'b0, 1'b1);
        chk(16'(acc_internal), 16'h0001, "flash on");
        wr(OFS_MISC, 8'h40);
        go(16'h0202, 1'b1, 1'b1);
        chk(acc_rdata, 16'h5859, "narrow word");
        boot(EBC_EXP_NARR);
        go(16'h4012, 1'b1, 1'b1);
        chk(acc_rdata, 16'h4849, "narrow mode word");
        boot(EBC_PERIPH);
        wr(OFS_PORT_A_DIR, 8'hFF);
        rchk(OFS_PORT_A_DIR, 8'h00, "dir periph");
        go(16'h4000, 1'b0, 1'b1);
        chk(16'(acc_internal), 16'h0001, "periph internal");

        // Both stretch fields at code n, narrow option toggling with n
        for (int n = 0; n < 4; n++) begin
            boot(EBC_EXP_WIDE);
            wr(OFS_MISC, {1'b0, 1'(n), 2'(n), 2'(n), 2'b00});
            go(16'h4000, 1'b0, 1'b1);
            if (n == 0) base = lat;
            chk(16'(lat - base), 16'(8 * n), "ext stretch");
            go(16'h0201, 1'b0, 1'b1);
            if (n == 0) fbase = lat;
            chk(16'(lat - fbase), 16'(8 * n), "follow stretch");
        end
        end_sim;
    end

    initial begin
        #200000;
        n_errors++;
        end_sim;
    end
endmodule
`default_nettype wire
